/* File: design/flash_dev_end.sv */
// device end: resume, deep power-down, release and identifier reads
`timescale 1ns/100ps
`include "flash_link_defs.svh"
module flash_dev_end
    import flash_link_pkg::*;
#(
    // arbitrary identity values
    parameter logic [7:0] MAKER_ID = 8'h5a,
    parameter logic [7:0] DEVICE_ID = 8'h3c
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic op_start,
    input wire logic op_done,
    input wire logic suspend_req,
    output logic busy,
    output logic suspend_flag,
    output logic resume_go,
    output logic powered_down,
    flash_link_if.dev link
);

    typedef enum logic [1:0] {
        pw_normal, pw_entering, pw_down, pw_leaving
    } pw_state_t;

    // ------------------------------------------------------------------
    // link side, on the serial clock
    // ------------------------------------------------------------------
    logic [5:0] cnt;
    logic [7:0] sr;
    frame_kind_t kind;
    frame_kind_t next_kind;
    logic lock_m;
    logic lock_s;
    logic busy_m;
    logic busy_s;
    logic locked;
    logic [15:0] sreg;
    logic [3:0] out;
    logic [3:0] oe;

    wire [7:0] opc = {sr[6:0], link.io[0]};
    wire opc_last = (cnt == `OPC_CLK - 6'h01);
    wire [5:0] in_len = (kind == fk_rel_id || kind == fk_md1)
        ? `IN_CLK_SINGLE
        : (kind == fk_md2) ? `IN_CLK_DUAL
        : (kind == fk_md4) ? `IN_CLK_QUAD : `IN_CLK_NONE;
    wire id_kind = (kind == fk_rel_id) || (kind == fk_md1)
        || (kind == fk_md2) || (kind == fk_md4);
    wire out_phase = id_kind && (cnt >= 6'(`OPC_CLK + in_len));
    wire [3:0] out_bits = (kind == fk_md4) ? sreg[15:12]
        : (kind == fk_md2) ? {2'h0, sreg[15:14]}
        : {2'h0, sreg[15], 1'h0};
    wire [3:0] out_mask = (kind == fk_md4) ? `OE_QUAD
        : (kind == fk_md2) ? `OE_DUAL : `OE_SINGLE_OUT;
    wire [15:0] rot = (kind == fk_md4) ? {sreg[11:0], sreg[15:12]}
        : (kind == fk_md2) ? {sreg[13:0], sreg[15:14]}
        : {sreg[14:0], sreg[15]};
    wire [15:0] load_word = (kind == fk_rel_id)
        ? {DEVICE_ID, DEVICE_ID} : {MAKER_ID, DEVICE_ID};

    // select high clears the clock count, so every frame starts at zero
    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            cnt <= 6'h00;
        end else if (cnt != `CNT_MAX) begin
            cnt <= 6'(cnt + 6'h01);
        end
    end

    always_ff @(posedge link.sclk) begin
        sr <= opc;
        lock_m <= locked;
        lock_s <= lock_m;
        busy_m <= busy;
        busy_s <= busy_m;
        kind <= next_kind;
    end

    // kind is left stable when the clock stops, for the frame-end check
    always_comb begin
        next_kind = kind;
        if (cnt < `OPC_CLK - 6'h01) begin
            next_kind = fk_none;
        end else if (opc_last) begin
            case (opc)
                `OP_RELEASE: begin
                    next_kind = busy_s ? fk_other : fk_rel;
                end
                `OP_POWERDOWN: begin
                    next_kind = lock_s ? fk_other : fk_pd;
                end
                `OP_RESUME: begin
                    next_kind = lock_s ? fk_other : fk_resume;
                end
                `OP_ID_SINGLE: begin
                    next_kind = (lock_s || busy_s) ? fk_other : fk_md1;
                end
                `OP_ID_DUAL: begin
                    next_kind = (lock_s || busy_s) ? fk_other : fk_md2;
                end
                `OP_ID_QUAD: begin
                    next_kind = (lock_s || busy_s) ? fk_other : fk_md4;
                end
                default: begin
                    next_kind = fk_other;
                end
            endcase
        end else if (kind == fk_rel) begin
            next_kind = fk_rel_id;
        end else if (kind == fk_pd || kind == fk_resume) begin
            next_kind = fk_other;
        end
    end

    // identifiers leave on falling edges and rotate, so they repeat
    always_ff @(negedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            oe <= 4'h0;
            out <= 4'h0;
            sreg <= 16'h0000;
        end else if (out_phase) begin
            oe <= out_mask;
            out <= out_bits;
            sreg <= rot;
        end else begin
            oe <= 4'h0;
            out <= 4'h0;
            sreg <= load_word;
        end
    end

    assign link.dev_io_out = out;
    assign link.dev_io_oe = oe;

    // ------------------------------------------------------------------
    // control side, on the system clock
    // ------------------------------------------------------------------
    logic cs_m;
    logic cs_s;
    logic cs_d;
    pw_state_t st;
    pw_state_t next_st;
    logic [15:0] timer;
    logic [15:0] next_timer;
    logic [1:0] rwait;

    // kind is quasi-static here: the serial clock has stopped by now
    wire frame_end = cs_s & ~cs_d;
    wire take_resume = frame_end && (kind == fk_resume)
        && suspend_flag && !busy && (st == pw_normal);
    wire take_pd = frame_end && (kind == fk_pd);
    wire take_rel = frame_end
        && (kind == fk_rel || kind == fk_rel_id);
    wire take_suspend = suspend_req && busy && !suspend_flag;
    wire busy_due = (rwait == 2'h1);
    wire [15:0] rel_len = (kind == fk_rel_id)
        ? 16'(`RELEASE_WITH_ID_CYC - 1) : 16'(`RELEASE_CYC - 1);

    always_ff @(posedge clk) begin
        if (rst) begin
            cs_m <= 1'h1;
            cs_s <= 1'h1;
            cs_d <= 1'h1;
        end else begin
            cs_m <= link.cs_n;
            cs_s <= cs_m;
            cs_d <= cs_s;
        end
    end

    always_comb begin
        next_st = st;
        next_timer = (timer == 16'h0000) ? timer : 16'(timer - 16'h0001);
        case (st)
            pw_normal: begin
                if (take_pd) begin
                    next_st = pw_entering;
                    next_timer = 16'(`POWERDOWN_ENTRY_CYC - 1);
                end
            end
            pw_entering: begin
                if (take_rel) begin
                    next_st = pw_leaving;
                    next_timer = rel_len;
                end else if (timer == 16'h0000) begin
                    next_st = pw_down;
                end
            end
            pw_down: begin
                if (take_rel) begin
                    next_st = pw_leaving;
                    next_timer = rel_len;
                end
            end
            pw_leaving: begin
                if (timer == 16'h0000) begin
                    next_st = pw_normal;
                end
            end
            default: begin
                next_st = pw_normal;
            end
        endcase
    end

    // power-up and power loss are both this reset
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= pw_normal;
            timer <= 16'h0000;
            locked <= 1'h0;
            powered_down <= 1'h0;
        end else begin
            st <= next_st;
            timer <= next_timer;
            locked <= (next_st != pw_normal);
            powered_down <= (next_st == pw_down);
        end
    end

    // busy returns one cycle short of the resume limit
    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'h0;
            suspend_flag <= 1'h0;
            rwait <= 2'h0;
            resume_go <= 1'h0;
        end else begin
            resume_go <= take_resume;
            if (take_resume) begin
                rwait <= 2'(`RESUME_BUSY_CYC - 1);
            end else if (rwait != 2'h0) begin
                rwait <= 2'(rwait - 2'h1);
            end
            if (op_start || busy_due) begin
                busy <= 1'h1;
            end else if (op_done || take_suspend) begin
                busy <= 1'h0;
            end
            if (take_suspend) begin
                suspend_flag <= 1'h1;
            end else if (take_resume) begin
                suspend_flag <= 1'h0;
            end
        end
    end

endmodule

/* File: design/flash_link_defs.svh */
// constants for the serial flash resume, power-down and identifier ends
//
// Overview of operation
// - resume taken only when suspended and idle
// - resume clears suspend, busy back within 200ns
// - otherwise resume ignored, nothing changes
// - power loss clears suspend, so resume ignored
// - host waits suspend interval after any resume
// - power-down needs select high right after opcode
// - power-down entered within the entry time
// - powered down, only release opcode is recognised
// - device starts in normal operation
// - release waits release time before normal operation
// - host keeps select high during release time
// - identifier after three dummy bytes, MSB first
// - identifier repeats until select goes high
// - host waits release-with-id time after release
// - release/identifier ignored while busy
// - maker then device id after zero address
// - dual read, address and ids two bits
// - quad read, four dummies, four bits
// - dual/quad ids alternate until select high
// - host sends mode bits Fx in dual read
// - suspend sets flag, clears busy
`ifndef FLASH_LINK_DEFS_SVH
`define FLASH_LINK_DEFS_SVH

// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define OP_RESUME 8'h7a
`define OP_POWERDOWN 8'hb9
`define OP_RELEASE 8'hab
`define OP_ID_SINGLE 8'h90
`define OP_ID_DUAL 8'h92
`define OP_ID_QUAD 8'h94

// ----------------------------------------------------------------------
// frame layout, in serial clocks
// ----------------------------------------------------------------------
`define OPC_CLK 6'h08
`define IN_CLK_NONE 6'h00
`define IN_CLK_SINGLE 6'h18
`define IN_CLK_DUAL 6'h10
`define IN_CLK_QUAD 6'h0a
`define OUT_CLK_SINGLE 6'h10
`define OUT_CLK_DUAL 6'h08
`define OUT_CLK_QUAD 6'h04
`define DUAL_MODE_FIRST 6'h0c
`define DUAL_MODE_END 6'h0e
`define DUAL_MODE_BITS 4'h3
`define CNT_MAX 6'h3f
`define OE_SINGLE_IN 4'h1
`define OE_SINGLE_OUT 4'h2
`define OE_DUAL 4'h3
`define OE_QUAD 4'hf

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_NS 100
`define RESUME_BUSY_NS 200
`define POWERDOWN_ENTRY_TIME_NS 3000
`define RELEASE_TIME_NS 3000
`define RELEASE_WITH_ID_TIME_NS 1800
`define SUSPEND_INTERVAL_NS 20000
`define RESUME_BUSY_CYC (`RESUME_BUSY_NS / `CLK_NS)
`define POWERDOWN_ENTRY_CYC (`POWERDOWN_ENTRY_TIME_NS / `CLK_NS)
`define RELEASE_CYC ((`RELEASE_TIME_NS + `CLK_NS - 1) / `CLK_NS)
`define RELEASE_WITH_ID_CYC \
    ((`RELEASE_WITH_ID_TIME_NS + `CLK_NS - 1) / `CLK_NS)
`define SUSPEND_INTERVAL_CYC \
    ((`SUSPEND_INTERVAL_NS + `CLK_NS - 1) / `CLK_NS)
`define CS_GAP_CYC 4
`define SCLK_RISE 2'h2
`define SCLK_LAST 2'h3

`endif

/* File: design/flash_link_pkg.sv */
// types shared by both ends of the serial flash link
package flash_link_pkg;
    typedef enum logic [3:0] {
        fk_none, fk_pd, fk_resume, fk_rel, fk_rel_id,
        fk_md1, fk_md2, fk_md4, fk_other
    } frame_kind_t;

    typedef enum logic [2:0] {
        c_powerdown, c_release, c_release_id, c_resume,
        c_id_single, c_id_dual, c_id_quad
    } cmd_t;
endpackage

/* File: design/flash_link_if.sv */
// serial flash link: select, clock and four shared data lines
`timescale 1ns/100ps
interface flash_link_if;
    logic cs_n;
    logic sclk;
    logic [3:0] host_io_out;
    logic [3:0] host_io_oe;
    logic [3:0] dev_io_out;
    logic [3:0] dev_io_oe;
    logic [3:0] io;

    // undriven lines float high, as with pull-ups
    assign io = (host_io_oe & host_io_out)
        | (~host_io_oe & dev_io_oe & dev_io_out)
        | (~host_io_oe & ~dev_io_oe);

    modport host (
        output cs_n,
        output sclk,
        output host_io_out,
        output host_io_oe,
        input io
    );

    modport dev (
        input cs_n,
        input sclk,
        input io,
        output dev_io_out,
        output dev_io_oe
    );
endinterface

/* File: design/flash_host_end.sv */
// host end: issues resume, power-down, release and identifier frames
`timescale 1ns/100ps
`include "flash_link_defs.svh"
module flash_host_end
    import flash_link_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire cmd_t cmd_op,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    flash_link_if.host link
);

    typedef enum logic [1:0] {h_idle, h_shift, h_end, h_gap} host_state_t;

    host_state_t st;
    cmd_t op;
    logic [1:0] div;
    logic [5:0] idx;
    logic [15:0] gap;
    logic [15:0] cap;
    logic [3:0] io_m;
    logic [3:0] io_s;
    logic cs_n;
    logic sclk;
    logic [3:0] hout;
    logic [3:0] hoe;

    // ------------------------------------------------------------------
    // frame shape of the latched command
    // ------------------------------------------------------------------
    wire [7:0] opcode = (op == c_powerdown) ? `OP_POWERDOWN
        : (op == c_resume) ? `OP_RESUME
        : (op == c_id_single) ? `OP_ID_SINGLE
        : (op == c_id_dual) ? `OP_ID_DUAL
        : (op == c_id_quad) ? `OP_ID_QUAD : `OP_RELEASE;
    wire [5:0] n_in = (op == c_id_single || op == c_release_id)
        ? `IN_CLK_SINGLE
        : (op == c_id_dual) ? `IN_CLK_DUAL
        : (op == c_id_quad) ? `IN_CLK_QUAD : `IN_CLK_NONE;
    wire [5:0] n_out = (op == c_id_single || op == c_release_id)
        ? `OUT_CLK_SINGLE
        : (op == c_id_dual) ? `OUT_CLK_DUAL
        : (op == c_id_quad) ? `OUT_CLK_QUAD : `IN_CLK_NONE;
    wire [5:0] last = 6'(`OPC_CLK + n_in + n_out - 6'h01);
    wire [5:0] in_end = 6'(`OPC_CLK + n_in);
    wire [5:0] mode_idx = 6'(idx - `OPC_CLK);
    wire [7:0] op_sh = 8'(opcode << idx[2:0]);
    wire in_mode = (op == c_id_dual) && (mode_idx >= `DUAL_MODE_FIRST)
        && (mode_idx < `DUAL_MODE_END);
    wire [3:0] in_oe = (op == c_id_quad) ? `OE_QUAD
        : (op == c_id_dual) ? `OE_DUAL : `OE_SINGLE_IN;
    wire [3:0] next_oe = (idx < `OPC_CLK) ? `OE_SINGLE_IN
        : (idx < in_end) ? in_oe : 4'h0;
    wire [3:0] next_out = (idx < `OPC_CLK) ? {3'h0, op_sh[7]}
        : in_mode ? `DUAL_MODE_BITS : 4'h0;
    wire [15:0] shifted = (op == c_id_quad) ? {cap[11:0], io_s}
        : (op == c_id_dual) ? {cap[13:0], io_s[1:0]}
        : {cap[14:0], io_s[1]};
    wire [15:0] gap_len = (op == c_release)
        ? 16'(`RELEASE_CYC - 1)
        : (op == c_release_id) ? 16'(`RELEASE_WITH_ID_CYC - 1)
        : (op == c_resume) ? 16'(`SUSPEND_INTERVAL_CYC - 1)
        : 16'(`CS_GAP_CYC - 1);

    // device lines are asynchronous to this clock
    always_ff @(posedge clk) begin
        io_m <= link.io;
        io_s <= io_m;
    end

    // ------------------------------------------------------------------
    // sequencer: four system clocks per serial clock
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= h_idle;
            op <= c_release;
            div <= 2'h0;
            idx <= 6'h00;
            gap <= 16'h0000;
            cap <= 16'h0000;
            cs_n <= 1'h1;
            sclk <= 1'h0;
            hout <= 4'h0;
            hoe <= 4'h0;
            cmd_ready <= 1'h1;
            rsp_valid <= 1'h0;
            rsp_data <= 16'h0000;
        end else begin
            rsp_valid <= 1'h0;
            case (st)
                h_idle: begin
                    if (cmd_valid && cmd_ready) begin
                        op <= cmd_op;
                        cmd_ready <= 1'h0;
                        cs_n <= 1'h0;
                        div <= 2'h0;
                        idx <= 6'h00;
                        st <= h_shift;
                    end
                end
                h_shift: begin
                    div <= 2'(div + 2'h1);
                    if (div == 2'h0) begin
                        sclk <= 1'h0;
                        hout <= next_out;
                        hoe <= next_oe;
                    end else if (div == `SCLK_RISE) begin
                        sclk <= 1'h1;
                    end else if (div == `SCLK_LAST) begin
                        if (idx >= in_end) begin
                            cap <= shifted;
                        end
                        idx <= 6'(idx + 6'h01);
                        if (idx == last) begin
                            st <= h_end;
                        end
                    end
                end
                h_end: begin
                    cs_n <= 1'h1;
                    sclk <= 1'h0;
                    hoe <= 4'h0;
                    hout <= 4'h0;
                    gap <= gap_len;
                    rsp_valid <= (n_out != 6'h00);
                    rsp_data <= cap;
                    st <= h_gap;
                end
                h_gap: begin
                    gap <= 16'(gap - 16'h0001);
                    if (gap == 16'h0000) begin
                        cmd_ready <= 1'h1;
                        st <= h_idle;
                    end
                end
                default: begin
                    st <= h_idle;
                end
            endcase
        end
    end

    assign link.cs_n = cs_n;
    assign link.sclk = sclk;
    assign link.host_io_out = hout;
    assign link.host_io_oe = hoe;

endmodule

/* File: tb/flash_resume_powerdown_id_assertions.sv */
// checker for the resume, power-down and identifier link ends
`timescale 1ns/100ps
module flash_resume_powerdown_id_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic [3:0] host_io_oe,
    input wire logic [3:0] dev_io_oe,
    input wire logic op_start,
    input wire logic suspend_req,
    input wire logic busy,
    input wire logic suspend_flag,
    input wire logic resume_go,
    input wire logic powered_down
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------------
    sequence resume_taken;
        resume_go && !suspend_flag;
    endsequence

    sequence busy_back;
        busy;
    endsequence

    // ------------------------------------------------------------------
    // resume and suspend
    // ------------------------------------------------------------------
    resume_cause_a: assert property (
        resume_go |-> $past(suspend_flag) && !$past(busy))
        else $error("resume taken without suspended idle state");
    resume_steps_a: assert property (
        resume_go |-> resume_taken ##1 busy_back)
        else $error("resume did not clear suspend then set busy");
    suspend_hold_a: assert property (
        $fell(suspend_flag) && !$past(rst) |-> resume_go)
        else $error("suspend flag cleared without a resume");
    suspend_take_a: assert property (
        suspend_req && busy && !suspend_flag && !op_start
        |=> suspend_flag && !busy)
        else $error("suspend did not set flag and clear busy");

    // ------------------------------------------------------------------
    // power state and data lines
    // ------------------------------------------------------------------
    power_up_a: assert property (
        $fell(rst) |-> !powered_down && !suspend_flag && !busy)
        else $error("device not in normal idle state after reset");
    down_no_resume_a: assert property (
        powered_down |-> !resume_go)
        else $error("resume acted on while powered down");
    frame_end_a: assert property (
        cs_n |-> dev_io_oe == 4'h0)
        else $error("device drives lines with select high");
    busy_quiet_a: assert property (
        busy |-> dev_io_oe == 4'h0)
        else $error("device answered an identifier read while busy");
    no_clash_a: assert property (
        (host_io_oe & dev_io_oe) == 4'h0)
        else $error("host and device drive a line together");
endmodule

/* File: tb/flash_resume_powerdown_id_test.sv */
// testbench joining host and device ends across the flash link
`timescale 1ns/100ps
module flash_resume_powerdown_id_test;
    import flash_link_pkg::*;
    localparam logic [7:0] MAKER = 8'ha5; // arbitrary value
    localparam logic [7:0] DEV = 8'h17; // arbitrary value
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic op_start = 1'h0;
    logic op_done = 1'h0;
    logic suspend_req = 1'h0;
    logic cmd_valid = 1'h0;
    cmd_t cmd_op = c_resume;
    logic busy, suspend_flag, resume_go, powered_down;
    logic cmd_ready, rsp_valid, got;
    logic [15:0] rsp_data, data;
    int err_count = 0;
    int n_compared = 0;
    int go_count = 0;
    int go0;

`define CHECK(name, exp, seen) begin \
    n_compared++; \
    if ((seen) !== (exp)) begin \
        err_count++; \
        $display("Error %s expected %h seen %h", name, exp, seen); \
    end \
end

    always #50 clk = ~clk;
    always @(posedge clk) if (resume_go === 1'h1) go_count++;

    flash_link_if flash_link_if_i ();
    flash_dev_end #(.MAKER_ID(MAKER), .DEVICE_ID(DEV)) flash_dev_end_i (
        .clk(clk), .rst(rst), .op_start(op_start), .op_done(op_done),
        .suspend_req(suspend_req), .busy(busy),
        .suspend_flag(suspend_flag), .resume_go(resume_go),
        .powered_down(powered_down), .link(flash_link_if_i.dev));
    flash_host_end flash_host_end_i (
        .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .link(flash_link_if_i.host));
    flash_resume_powerdown_id_assertions
        flash_resume_powerdown_id_assertions_i (
        .clk(clk), .rst(rst), .cs_n(flash_link_if_i.cs_n),
        .host_io_oe(flash_link_if_i.host_io_oe),
        .dev_io_oe(flash_link_if_i.dev_io_oe), .op_start(op_start),
        .suspend_req(suspend_req), .busy(busy),
        .suspend_flag(suspend_flag), .resume_go(resume_go),
        .powered_down(powered_down));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic pulse(ref logic sig);
        @(negedge clk) sig = 1'h1;
        @(negedge clk) sig = 1'h0;
    endtask

    // returns once the host's gap has run out, so the next may follow
    task automatic do_cmd(input cmd_t op);
        got = 1'h0;
        go0 = go_count;
        @(negedge clk);
        cmd_valid = 1'h1;
        cmd_op = op;
        @(negedge clk) cmd_valid = 1'h0;
        for (int i = 0; i < 600; i++) begin
            @(negedge clk);
            if (rsp_valid === 1'h1) begin
                got = 1'h1;
                data = rsp_data;
            end
            if (cmd_ready === 1'h1) break;
        end
        // a host that never comes back counts against the run
        `CHECK("command done", 1'h1, cmd_ready)
    endtask

    // the loop limit bounds the entry time
    task automatic wait_down();
        for (int i = 0; i < 40 && powered_down !== 1'h1; i++)
            @(negedge clk);
        `CHECK("entered down", 1'h1, powered_down)
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic id_reads();
        cmd_t ops[4] = '{c_id_single, c_id_dual, c_id_quad, c_release_id};
        logic [15:0] exp[4] = '{{MAKER, DEV}, {MAKER, DEV}, {MAKER, DEV},
            {DEV, DEV}};
        for (int i = 0; i < 4; i++) begin
            do_cmd(ops[i]);
            `CHECK("id response", 1'h1, got)
            `CHECK("id data", exp[i], data)
        end
    endtask

    task automatic resume_cases();
        do_cmd(c_resume);
        `CHECK("resume when idle", go0, go_count)
        pulse(op_start);
        pulse(suspend_req);
        `CHECK("suspend flag", 1'h1, suspend_flag)
        `CHECK("busy after suspend", 1'h0, busy)
        // set wins over the held suspend: busy and suspended together
        pulse(op_start);
        do_cmd(c_resume);
        `CHECK("resume while busy", go0, go_count)
        `CHECK("suspend kept", 1'h1, suspend_flag)
        pulse(op_done);
        do_cmd(c_resume);
        `CHECK("resume taken", go0 + 1, go_count)
        `CHECK("suspend cleared", 1'h0, suspend_flag)
        `CHECK("busy resumed", 1'h1, busy)
        do_cmd(c_id_single);
        `CHECK("id while busy", 16'hffff, data)
        `CHECK("busy untouched", 1'h1, busy)
        pulse(op_done);
    endtask

    task automatic power_down();
        // a suspended operation waits across the power-down
        pulse(op_start);
        pulse(suspend_req);
        do_cmd(c_powerdown);
        wait_down();
        do_cmd(c_id_single);
        `CHECK("id while down", 16'hffff, data)
        `CHECK("still down", 1'h1, powered_down)
        do_cmd(c_resume);
        `CHECK("resume while down", go0, go_count)
        `CHECK("suspend while down", 1'h1, suspend_flag)
        do_cmd(c_release);
        `CHECK("released", 1'h0, powered_down)
        do_cmd(c_id_single);
        `CHECK("id after release", {MAKER, DEV}, data)
        do_cmd(c_powerdown);
        wait_down();
        do_cmd(c_release_id);
        `CHECK("release id data", {DEV, DEV}, data)
        `CHECK("release id wakes", 1'h0, powered_down)
        do_cmd(c_resume);
        `CHECK("resume after wake", go0 + 1, go_count)
        pulse(op_done);
    endtask

    task automatic power_loss();
        pulse(op_start);
        pulse(suspend_req);
        @(negedge clk) rst = 1'h1;
        repeat (8) @(negedge clk);
        rst = 1'h0;
        `CHECK("suspend lost", 1'h0, suspend_flag)
        `CHECK("normal at power up", 1'h0, powered_down)
        do_cmd(c_resume);
        `CHECK("resume after loss", go0, go_count)
        `CHECK("busy after loss", 1'h0, busy)
    endtask

    // ------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // 17 frames of at most 300 cycles each, with ample margin
    initial begin
        #2000000;
        err_count++;
        final_report();
    end

    initial begin
        repeat (8) @(negedge clk);
        rst = 1'h0;
        @(negedge clk);
        `CHECK("down after reset", 1'h0, powered_down)
        id_reads();
        resume_cases();
        power_down();
        power_loss();
        final_report();
    end
endmodule
